// ---- verilog/malrt_top.sv ----
// Alert and interrupt status logic of the voltage and temperature monitor.
//
// Overview of operation
// - Select field: 00/11 default, 01 one-time, 10 comparator mode.
// - Unmasked out-of-limit voltage or temperature asserts alert if enabled.
// - Default and one-time modes: status read clears alert and status.
// - Comparator: temperature alert releases only once the fault is gone or the alert clear bit is set.
// - Comparator: status read during a persisting fault clears all bits but bit 4.
// - Status read after the fault is gone clears the whole register.
// - Outside one-time mode, a fault that remains reasserts alert after the next conversion.
// - Mask bits or alert enable low keep the alert output inactive.
// - Alerts never stop conversions; results stay readable meanwhile.
// - Alert pin is open drain: pulls low when asserted, floats otherwise.
// - Default: above hot interrupts, repeating until below hysteresis.
// - One-time: single interrupt above hot; next when below hysteresis.
// - Comparator: alert low above hot, repeating until below hot.
// - Comparator: status read leaves the temperature alert unchanged, and the temperature bit while still above hot.
// - Status bits 0-3 flag the four voltage inputs, bit 4 temperature.
// - A voltage is out of range below its low or above its high limit.
// - A mask bit suppresses that input's status bit and alert.
`timescale 1ns/10ps
`default_nettype none
`include "malrt_params.svh"

module malrt_top
   import malrt_pkg::*;
   (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       ce,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output var  logic [7:0] reg_rdata,
   input  wire logic       volt_done,
   input  wire logic [1:0] volt_ch,
   input  wire logic [7:0] volt_meas,
   input  wire logic [7:0] volt_lo,
   input  wire logic [7:0] volt_hi,
   input  wire logic       temp_done,
   input  wire logic [7:0] temp_meas,
   output logic            conv_run,
   input  wire logic       alert_in,
   output logic            alert_out,
   output logic            alert_oe_n
   );

   logic [7:0] hot_r;
   logic [7:0] hyst_r;
   logic [7:0] cfg_r;
   logic [4:0] mask_r;
   logic [1:0] tcfg_r;
   logic [4:0] status_r;
   logic [3:0] vst_r;
   logic       tst_r;
   logic [3:0] valrt_r;
   logic       srst_r;
   logic       alert_oe_n_r;
   logic [7:0] rdata_r;
   logic [7:0] rmux;
   logic       rst_all;
   logic       wr_ok;
   logic       status_rd;
   logic       volt_bad;
   logic       alert_any;
   logic       line_low;
   logic [3:0] vev;

   malrt_tif u_tif ();

   // Bit 7 of the configuration register restores every register.
   assign rst_all   = rst | srst_r;
   assign wr_ok     = ce & reg_wr;
   assign status_rd = reg_rd & (reg_addr == `MALRT_ADDR_STATUS);

   // The line level is for observation only; it never gates the drive.
   assign line_low  = ~alert_in;

   // Temperature compares are two's complement against the limits.
   assign u_tif.temp_done  = temp_done;
   assign u_tif.over_hot   = $signed(temp_meas) > $signed(hot_r);
   assign u_tif.below_hyst = $signed(temp_meas) < $signed(hyst_r);
   assign u_tif.mode       = malrt_mode(tcfg_r);
   assign u_tif.status_rd  = status_rd;
   assign u_tif.masked     = mask_r[`MALRT_ST_TEMP];
   assign u_tif.alrt_clr   = cfg_r[`MALRT_CFG_ALERT_CLR];

   malrt_temp u_temp (
      .clk (clk),
      .rst (rst_all),
      .ce  (ce),
      .tif (u_tif.eng)
   );

   assign volt_bad = (volt_meas < volt_lo) | (volt_meas > volt_hi);

   always_ff @(posedge clk) begin
      if (rst) begin
         srst_r <= 1'b0;
      end else if (ce) begin
         srst_r <= reg_wr && reg_addr == `MALRT_ADDR_CFG
                   && reg_wdata[`MALRT_CFG_SOFT_RST];
      end
   end

   always_ff @(posedge clk) begin
      if (rst_all) begin
         hot_r  <= `MALRT_RST_HOT;
         hyst_r <= `MALRT_RST_HYST;
      end else if (wr_ok) begin
         if (reg_addr == `MALRT_ADDR_HOT) begin
            hot_r <= reg_wdata;
         end
         if (reg_addr == `MALRT_ADDR_HYST) begin
            hyst_r <= reg_wdata;
         end
      end
   end

   // Reserved configuration bits and the self-clearing reset bit read zero.
   always_ff @(posedge clk) begin
      if (rst_all) begin
         cfg_r <= `MALRT_RST_CFG;
      end else if (wr_ok && reg_addr == `MALRT_ADDR_CFG) begin
         cfg_r <= reg_wdata & `MALRT_CFG_RW_MASK;
      end
   end

   always_ff @(posedge clk) begin
      if (rst_all) begin
         mask_r <= `MALRT_RST_MASK;
      end else if (wr_ok && reg_addr == `MALRT_ADDR_MASK) begin
         mask_r <= reg_wdata[4:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst_all) begin
         tcfg_r <= `MALRT_RST_TCFG;
      end else if (wr_ok && reg_addr == `MALRT_ADDR_TCFG) begin
         tcfg_r <= reg_wdata[1:0];
      end
   end

   // One status bit and one pending alert per voltage channel.
   generate
      for (genvar i = 0; i < `MALRT_NUM_VOLT; i++) begin : g_volt
         assign vev[i] = volt_done && volt_ch == 2'(i) && volt_bad
                         && !mask_r[i];

         // A fault in the same cycle as the read survives it.
         always_ff @(posedge clk) begin
            if (rst_all) begin
               vst_r[i] <= 1'b0;
            end else if (ce) begin
               if (vev[i]) begin
                  vst_r[i] <= 1'b1;
               end else if (status_rd) begin
                  vst_r[i] <= 1'b0;
               end
            end
         end

         always_ff @(posedge clk) begin
            if (rst_all) begin
               valrt_r[i] <= 1'b0;
            end else if (ce) begin
               if (vev[i]) begin
                  valrt_r[i] <= 1'b1;
               end else if (status_rd || cfg_r[`MALRT_CFG_ALERT_CLR]) begin
                  valrt_r[i] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (rst_all) begin
         tst_r <= 1'b0;
      end else if (ce) begin
         if (u_tif.ev) begin
            tst_r <= 1'b1;
         end else if (status_rd && !u_tif.keep) begin
            tst_r <= 1'b0;
         end
      end
   end

   assign status_r = {tst_r, vst_r};

   assign alert_any = cfg_r[`MALRT_CFG_ALERT_EN]
                      & ~cfg_r[`MALRT_CFG_ALERT_CLR]
                      & |({u_tif.talert, valrt_r} & ~mask_r);

   // Registered so the shared wire never sees decode glitches.
   always_ff @(posedge clk) begin
      if (rst_all) begin
         alert_oe_n_r <= 1'b1;
      end else if (ce) begin
         alert_oe_n_r <= ~alert_any;
      end
   end

   assign alert_out  = 1'b0;
   assign alert_oe_n = alert_oe_n_r;

   // Conversions run regardless of any pending alert.
   assign conv_run = cfg_r[`MALRT_CFG_START]
                     & ~cfg_r[`MALRT_CFG_ALERT_CLR];

   always_comb begin
      rmux = 8'h00;
      unique case (reg_addr)
         `MALRT_ADDR_HOT:    rmux = hot_r;
         `MALRT_ADDR_HYST:   rmux = hyst_r;
         `MALRT_ADDR_CFG:    rmux = cfg_r;
         `MALRT_ADDR_STATUS: rmux = {3'h0, status_r & ~mask_r};
         `MALRT_ADDR_MASK:   rmux = {3'h0, mask_r};
         `MALRT_ADDR_TCFG:   rmux = {6'h00, tcfg_r};
         default:            rmux = {7'h00, line_low};
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst_all) begin
         rdata_r <= 8'h00;
      end else if (ce && reg_rd) begin
         rdata_r <= rmux;
      end
   end

   assign reg_rdata = rdata_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_quiet_read;
      ce && status_rd && !srst_r && !(|vev) && !u_tif.ev;
   endsequence

   sequence s_volt_fault;
      ce && vev[0] ##1 ce && cfg_r[`MALRT_CFG_ALERT_EN]
         && !cfg_r[`MALRT_CFG_ALERT_CLR] && !mask_r[0];
   endsequence

   property p_rd_clr;
      s_quiet_read |=> status_r[3:0] == 4'h0;
   endproperty
   a_rd_clr: assert property (p_rd_clr)
      else $error("read left voltage status");

   property p_clr_all;
      s_quiet_read and (!u_tif.keep) |=> status_r == 5'h00;
   endproperty
   a_clr_all: assert property (p_clr_all)
      else $error("read left status bits");

   property p_keep;
      ce && status_rd && u_tif.keep && status_r[`MALRT_ST_TEMP] && !srst_r
         |=> status_r[`MALRT_ST_TEMP];
   endproperty
   a_keep: assert property (p_keep)
      else $error("temperature bit lost on read");

   property p_disable;
      ce && !cfg_r[`MALRT_CFG_ALERT_EN] |=> alert_oe_n;
   endproperty
   a_disable: assert property (p_disable)
      else $error("alert driven while disabled");

   property p_clear_bit;
      ce && cfg_r[`MALRT_CFG_ALERT_CLR] |=> alert_oe_n;
   endproperty
   a_clear_bit: assert property (p_clear_bit)
      else $error("alert clear bit left alert driven");

   property p_volt;
      s_volt_fault |=> !alert_oe_n;
   endproperty
   a_volt: assert property (p_volt)
      else $error("voltage fault gave no alert");

   property p_vmap;
      ce && volt_done && volt_ch == 2'h2 && volt_meas > volt_hi
         && !mask_r[2] && !srst_r |=> status_r[2];
   endproperty
   a_vmap: assert property (p_vmap)
      else $error("high voltage not flagged");

   property p_mask;
      ce && reg_rd && reg_addr == `MALRT_ADDR_STATUS && mask_r[0] && !srst_r
         |=> !reg_rdata[0];
   endproperty
   a_mask: assert property (p_mask)
      else $error("masked status bit read as set");

   // Only a configuration write or a soft reset may stop the loop.
   property p_run;
      conv_run && !alert_oe_n && !srst_r
         && !(reg_wr && reg_addr == `MALRT_ADDR_CFG) |=> conv_run;
   endproperty
   a_run: assert property (p_run)
      else $error("alert stopped conversions");

endmodule

`default_nettype wire

// ---- verilog/malrt_params.svh ----
// Register offsets, field positions, reset values of the alert logic.
`ifndef MALRT_PARAMS_SVH
`define MALRT_PARAMS_SVH

`define MALRT_ADDR_HOT      8'h39
`define MALRT_ADDR_HYST     8'h3a
`define MALRT_ADDR_CFG      8'h40
`define MALRT_ADDR_STATUS   8'h41
`define MALRT_ADDR_MASK     8'h43
`define MALRT_ADDR_TCFG     8'h4b

`define MALRT_RST_HOT       8'h50
`define MALRT_RST_HYST      8'h41
`define MALRT_RST_CFG       8'h00
`define MALRT_RST_MASK      5'h00
`define MALRT_RST_TCFG      2'h0

`define MALRT_CFG_START     0
`define MALRT_CFG_ALERT_EN  1
`define MALRT_CFG_ALERT_CLR 3
`define MALRT_CFG_SOFT_RST  7
`define MALRT_CFG_RW_MASK   8'h3b

`define MALRT_ST_TEMP       4
`define MALRT_NUM_VOLT      4

`endif

// ---- verilog/malrt_pkg.sv ----
// Types shared by the alert logic modules.
`default_nettype none

package malrt_pkg;

   typedef enum logic [1:0] {
      TM_DEFAULT,
      TM_ONETIME,
      TM_COMPARE
   } malrt_tmode_t;

   function automatic malrt_tmode_t malrt_mode(input logic [1:0] f);
      malrt_tmode_t m;
      m = TM_DEFAULT;
      if (f == 2'h1) begin
         m = TM_ONETIME;
      end else if (f == 2'h2) begin
         m = TM_COMPARE;
      end
      return m;
   endfunction

endpackage

`default_nettype wire

// ---- verilog/malrt_tif.sv ----
// Carrier between the register side and the temperature mode engine.
`timescale 1ns/10ps
`default_nettype none

interface malrt_tif
   import malrt_pkg::*;
   ();
   logic         temp_done;
   logic         over_hot;
   logic         below_hyst;
   malrt_tmode_t mode;
   logic         status_rd;
   logic         masked;
   logic         alrt_clr;
   logic         ev;
   logic         keep;
   logic         talert;

   modport ctl (output temp_done, over_hot, below_hyst, mode, status_rd,
                output masked, alrt_clr, input ev, keep, talert);
   modport eng (input temp_done, over_hot, below_hyst, mode, status_rd,
                input masked, alrt_clr, output ev, keep, talert);
endinterface

`default_nettype wire

// ---- verilog/malrt_temp.sv ----
// Temperature interrupt mode engine: default, one-time and comparator.
`timescale 1ns/10ps
`default_nettype none

module malrt_temp
   import malrt_pkg::*;
   (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic ce,
   malrt_tif.eng     tif
   );

   logic armed_r;
   logic fired_r;
   logic cmp_r;
   logic talert_r;
   logic ev_raw;

   always_comb begin
      ev_raw = 1'b0;
      if (tif.temp_done) begin
         unique case (tif.mode)
            TM_DEFAULT: ev_raw = tif.over_hot
                               | (armed_r & ~tif.below_hyst);
            TM_ONETIME: ev_raw = (~fired_r & tif.over_hot)
                               | (fired_r & tif.below_hyst);
            TM_COMPARE: ev_raw = tif.over_hot;
         endcase
      end
   end

   assign tif.ev     = ev_raw & ~tif.masked;
   assign tif.keep   = (tif.mode == TM_COMPARE) & cmp_r;
   assign tif.talert = talert_r;

   // Hysteresis band for default mode.
   always_ff @(posedge clk) begin
      if (rst) begin
         armed_r <= 1'b0;
      end else if (ce && tif.temp_done) begin
         if (tif.over_hot) begin
            armed_r <= 1'b1;
         end else if (tif.below_hyst) begin
            armed_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         fired_r <= 1'b0;
      end else if (ce) begin
         if (tif.mode != TM_ONETIME) begin
            fired_r <= 1'b0;
         end else if (tif.temp_done) begin
            fired_r <= fired_r ? ~tif.below_hyst : tif.over_hot;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cmp_r <= 1'b0;
      end else if (ce && tif.temp_done) begin
         cmp_r <= tif.over_hot;
      end
   end

   // Comparator alert ignores status reads; a new event beats any clear.
   always_ff @(posedge clk) begin
      if (rst) begin
         talert_r <= 1'b0;
      end else if (ce) begin
         if (tif.ev) begin
            talert_r <= 1'b1;
         end else if (tif.mode == TM_COMPARE) begin
            if (tif.temp_done || tif.alrt_clr) begin
               talert_r <= 1'b0;
            end
         end else if (tif.status_rd || tif.alrt_clr) begin
            talert_r <= 1'b0;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_cmp_hold;
      ce && talert_r && tif.mode == TM_COMPARE && tif.status_rd
         && !tif.temp_done && !tif.alrt_clr |=> talert_r;
   endproperty
   a_cmp_hold: assert property (p_cmp_hold)
      else $error("read cleared comparator alert");

   property p_once;
      tif.mode == TM_ONETIME && fired_r && tif.over_hot
         && !tif.below_hyst |-> !tif.ev;
   endproperty
   a_once: assert property (p_once)
      else $error("one-time mode fired twice");

   property p_repeat;
      tif.mode == TM_DEFAULT && tif.temp_done && armed_r && !tif.masked
         && !tif.below_hyst |-> tif.ev;
   endproperty
   a_repeat: assert property (p_repeat)
      else $error("default mode did not repeat");

endmodule

`default_nettype wire

// ---- tb/malrt_host_model.sv ----
// Host-side model of the shared, pulled-up alert line.
`timescale 1ns/10ps
`default_nettype none

module malrt_host_model (
   input  wire logic alert_out,
   input  wire logic alert_oe_n,
   input  wire logic other_low,
   output logic      alert_in
);
   logic dut_low;

   // The line is open drain with a pull-up, so it reads high unless a party
   // pulls it; the far device lets the bench test the wired sharing.
   assign dut_low  = ~alert_oe_n & ~alert_out;
   assign alert_in = (dut_low | other_low) ? 1'b0 : 1'b1;
endmodule

`default_nettype wire

// ---- tb/tb_malrt_top.sv ----
// Self-checking bench for the alert and interrupt status logic.
`timescale 1ns/10ps
`default_nettype none
`include "malrt_params.svh"

module tb_malrt_top;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic       ce = 1'b1;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic       volt_done = 1'b0;
   logic       temp_done = 1'b0;
   logic       other_low = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] volt_meas = 8'h00;
   logic [7:0] volt_lo = 8'h00;
   logic [7:0] volt_hi = 8'h00;
   logic [7:0] temp_meas = 8'h00;
   logic [1:0] volt_ch = 2'h0;
   logic [7:0] reg_rdata;
   logic       conv_run;
   logic       alert_in;
   logic       alert_out;
   logic       alert_oe_n;
   int         failures = 0;
   int         num_checks = 0;
   int         cycles = 0;
   logic [7:0] d, v, lo, hi;
   logic [1:0] ch;
   logic       f, cm, ot;
   logic [7:0] corner [4] = '{8'h10, 8'h0f, 8'hf0, 8'hf1};

   malrt_top DUT (.clk(clk), .rst(rst), .ce(ce), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .volt_done(volt_done), .volt_ch(volt_ch),
      .volt_meas(volt_meas), .volt_lo(volt_lo), .volt_hi(volt_hi),
      .temp_done(temp_done), .temp_meas(temp_meas), .conv_run(conv_run),
      .alert_in(alert_in), .alert_out(alert_out), .alert_oe_n(alert_oe_n));

   malrt_host_model host (.alert_out(alert_out), .alert_oe_n(alert_oe_n),
      .other_low(other_low), .alert_in(alert_in));

   always #2.5 clk = ~clk;

   task automatic chk(input string what, input logic [7:0] seen,
                      input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic complete_run();
      if (failures == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] val);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= val;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~val;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] val);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 val = reg_rdata;
   endtask

   task automatic volt(input logic [1:0] c, input logic [7:0] m, l, h);
      @(posedge clk);
      volt_done <= 1'b1;
      volt_ch <= c;
      volt_meas <= m;
      volt_lo <= l;
      volt_hi <= h;
      @(posedge clk);
      volt_done <= 1'b0;
      volt_meas <= ~m;
   endtask

   task automatic temp(input logic [7:0] t);
      @(posedge clk);
      temp_done <= 1'b1;
      temp_meas <= t;
      @(posedge clk);
      temp_done <= 1'b0;
      temp_meas <= ~t;
   endtask

   // Alert lands one edge after status; three edges leave margin.
   task automatic settle();
      repeat (3) @(posedge clk);
      #1;
   endtask

   // Expected status byte of one voltage conversion.
   function automatic logic [7:0] vstat(input logic [1:0] c,
                                        input logic [7:0] m, l, h);
      return ((m < l) || (m > h)) ? (8'h01 << c) : 8'h00;
   endfunction

   task automatic chk_alert(input logic e);
      chk("alert_oe_n", {7'h0, alert_oe_n}, {7'h0, e});
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      rd(a, d);
      chk("reg_rdata", d, e);
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         complete_run();
      end
   end

   initial begin
      void'($urandom(32'h8836));
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rd_chk(`MALRT_ADDR_HOT, `MALRT_RST_HOT);
      rd_chk(`MALRT_ADDR_HYST, `MALRT_RST_HYST);
      rd_chk(`MALRT_ADDR_CFG, `MALRT_RST_CFG);
      rd_chk(`MALRT_ADDR_MASK, 8'h00);
      rd_chk(`MALRT_ADDR_TCFG, 8'h00);
      rd_chk(`MALRT_ADDR_STATUS, 8'h00);
      chk_alert(1'b1);
      wr(`MALRT_ADDR_CFG, 8'h03);
      for (int i = 0; i < 12; i++) begin
         v = 8'($urandom);
         lo = 8'($urandom);
         hi = 8'($urandom);
         ch = 2'($urandom);
         if (i < 4) begin
            v = corner[i];
            lo = 8'h10;
            hi = 8'hf0;
         end
         f = |vstat(ch, v, lo, hi);
         volt(ch, v, lo, hi);
         settle();
         chk_alert(~f);
         chk("conv_run", {7'h0, conv_run}, 8'h01);
         rd_chk(`MALRT_ADDR_STATUS, vstat(ch, v, lo, hi));
         settle();
         chk_alert(1'b1);
      end
      // With the enable low, events and writes must leave no trace.
      @(posedge clk);
      ce <= 1'b0;
      volt(2'h2, 8'h00, 8'h10, 8'hf0);
      wr(`MALRT_ADDR_HOT, 8'h7f);
      ce <= 1'b1;
      settle();
      chk_alert(1'b1);
      rd_chk(`MALRT_ADDR_STATUS, 8'h00);
      rd_chk(`MALRT_ADDR_HOT, `MALRT_RST_HOT);
      volt(2'h3, 8'hff, 8'h10, 8'hf0);
      settle();
      chk_alert(1'b0);
      rd_chk(8'h00, 8'h01);
      wr(`MALRT_ADDR_CFG, 8'h0b);
      settle();
      chk_alert(1'b1);
      chk("conv_run", {7'h0, conv_run}, 8'h00);
      wr(`MALRT_ADDR_CFG, 8'h03);
      settle();
      chk_alert(1'b1);
      rd_chk(`MALRT_ADDR_STATUS, 8'h08);
      wr(`MALRT_ADDR_MASK, 8'h01);
      volt(2'h0, 8'h00, 8'h10, 8'hf0);
      settle();
      chk_alert(1'b1);
      rd_chk(`MALRT_ADDR_STATUS, 8'h00);
      wr(`MALRT_ADDR_MASK, 8'h00);
      wr(`MALRT_ADDR_CFG, 8'h01);
      volt(2'h1, 8'hff, 8'h10, 8'hf0);
      settle();
      chk_alert(1'b1);
      rd_chk(`MALRT_ADDR_STATUS, 8'h02);
      other_low <= 1'b1;
      settle();
      rd_chk(8'h00, 8'h01);
      other_low <= 1'b0;
      settle();
      rd_chk(8'h00, 8'h00);
      chk("alert_out", {7'h0, alert_out}, 8'h00);
      // Every select code, 11 included, runs the same temperature story.
      for (int m = 0; m < 4; m++) begin
         @(posedge clk);
         rst <= 1'b1;
         repeat (2) @(posedge clk);
         rst <= 1'b0;
         cm = (m == 2);
         ot = (m == 1);
         wr(`MALRT_ADDR_CFG, 8'h03);
         wr(`MALRT_ADDR_TCFG, 8'(m));
         temp(8'h60);
         volt(2'h0, 8'h00, 8'h10, 8'hf0);
         settle();
         chk_alert(1'b0);
         rd_chk(`MALRT_ADDR_STATUS, 8'h11);
         rd_chk(`MALRT_ADDR_STATUS, cm ? 8'h10 : 8'h00);
         settle();
         chk_alert(~cm);
         temp(8'h60);
         settle();
         chk_alert(ot);
         rd_chk(`MALRT_ADDR_STATUS, ot ? 8'h00 : 8'h10);
         settle();
         chk_alert(~cm);
         temp(8'h48);
         settle();
         chk_alert(ot | cm);
         rd_chk(`MALRT_ADDR_STATUS, ot ? 8'h00 : 8'h10);
         rd_chk(`MALRT_ADDR_STATUS, 8'h00);
         settle();
         chk_alert(1'b1);
         temp(8'h30);
         settle();
         chk_alert(~ot);
      end
      wr(`MALRT_ADDR_HOT, 8'h7f);
      wr(`MALRT_ADDR_CFG, 8'h80);
      rd_chk(`MALRT_ADDR_HOT, `MALRT_RST_HOT);
      rd_chk(`MALRT_ADDR_CFG, `MALRT_RST_CFG);
      rd_chk(`MALRT_ADDR_TCFG, 8'h00);
      complete_run();
   end
endmodule

`default_nettype wire
